// ---- src/pmc_consts.svh ----
/*
  Constants of the power-mode controller: register addresses, bit positions,
  reset values and cycle counts. Assumes inclusion by bare name only.
*/
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// Register addresses on the special function register port
`define PMC_ADDR_PCTL2    8'h44
`define PMC_ADDR_PCTL0    8'h87
`define PMC_ADDR_FLAGS    8'h97

// Reset values
`define PMC_RST_PCTL0     8'h00
`define PMC_RST_FLAGS     8'h00
`define PMC_RST_PCTL2     8'h05

// Power control zero bits
`define PMC_B_IDLE        0
`define PMC_B_PDOWN       1
`define PMC_B_POWERON     4
`define PMC_PCTL0_GENMASK 8'hec

// System event flag bits
`define PMC_B_SOFTRST     7
`define PMC_B_PINRST      6
`define PMC_B_MISSCLK     5
`define PMC_B_RTCOVF      4
`define PMC_B_STACKW      3
`define PMC_B_BROWNOUT_DETECTOR_ONE        2
`define PMC_B_BROWNOUT_DETECTOR_ZERO        1
`define PMC_B_WDTOVF      0

// Power control two bits
`define PMC_B_KEEPAWAKE   7
`define PMC_B_LVL_HI      5
`define PMC_B_LVL_LO      4
`define PMC_B_BOD1RE      3
`define PMC_B_BOD1EN      2
`define PMC_B_BOD0RE      1
`define PMC_PCTL2_WMASK   8'hbe
`define PMC_PCTL2_FIXED   8'h01

// Timing
`define PMC_WAKE_COUNT    1024
`define PMC_IDLE_RST_MC   2'd2
`define PMC_HOLD_ONE      2'd1

`endif

// ---- src/pmc_pkg.sv ----
/*
  Types of the power-mode controller: controller states, detector levels
  and the packed groups of event and wake signals.
  Assumes the constants header is on the include path.
*/
package pmc_pkg;

  typedef enum logic [2:0]
  {
    PMC_RUN,
    PMC_IDLE,
    PMC_PDOWN,
    PMC_WAKE_TIMING,
    PMC_WAIT_RST_LOW,
    PMC_IDLE_RST_HOLD,
    PMC_CORE_RESET
  } pmc_state_e;

  // Detector one thresholds, in field order 00..11
  typedef enum logic [1:0]
  {
    PMC_LVL_2V0,
    PMC_LVL_2V4,
    PMC_LVL_3V7,
    PMC_LVL_4V2
  } pmc_level_e;

  // One-cycle events from reset logic and monitors
  typedef struct packed
  {
    logic powerOn;
    logic softReset;
    logic pinReset;
    logic missingClock;
    logic rtcOverflow;
    logic bod1Match;
    logic bod0Match;
    logic wdtOverflow;
  } pmc_events_s;

  // External interrupt pin configuration
  typedef struct packed
  {
    logic [3:0] enable;
    logic [3:0] activeHigh;
  } pmc_extcfg_s;

  // Registered wake requests
  typedef struct packed
  {
    logic extWake;
    logic keypadWake;
    logic rstRise;
  } pmc_wake_s;

endpackage : pmc_pkg

// ---- src/pmc_wake_timer.sv ----
/*
  Oscillator restart timer for wakeups from power-down.
  Assumes run stays high from wake until done is seen.
*/
`timescale 1ns/10ps
`include "pmc_consts.svh"

module pmc_wake_timer #(
  parameter int unsigned WAKE_COUNT = `PMC_WAKE_COUNT
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      done
);
  import pmc_pkg::*;

  typedef struct packed
  {
    logic [15:0] count;
    logic        done;
  } pmc_timer_s;

  pmc_timer_s st_r;
  pmc_timer_s st_nxt;

  // Counts while running, full flag when the last count is reached
  always_comb
  begin
    st_nxt = st_r;
    if (!run)
    begin
      st_nxt.count = 16'h0000;
      st_nxt.done  = 1'b0;
    end
    else if (st_r.count == 16'(WAKE_COUNT - 1))
      st_nxt.done  = 1'b1;
    else
      st_nxt.count = st_r.count + 16'h0001;
  end

  // State register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign done = st_r.done;

endmodule : pmc_wake_timer

// ---- src/pmc_wake_detect.sv ----
/*
  Wake source detection for power-down: external interrupt pins, keypad
  match and the reset pin rising edge. Assumes pins synchronous to clock.
*/
`timescale 1ns/10ps
`include "pmc_consts.svh"

module pmc_wake_detect (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                pdActive,
  input  wire logic [3:0]          extIrqPin,
  input  pmc_pkg::pmc_extcfg_s     extCfg,
  input  wire logic                keypadMatch,
  input  wire logic                keypadIrqEnable,
  input  wire logic                rstPin,
  output pmc_pkg::pmc_wake_s       wake
);
  import pmc_pkg::*;

  typedef struct packed
  {
    logic      rstPrev;
    pmc_wake_s wake;
  } pmc_detect_s;

  pmc_detect_s st_r;
  pmc_detect_s st_nxt;
  logic [3:0]  pinActive;

  // Edge modes are read as levels in power-down
  // forced level sense
  assign pinActive = extCfg.enable & ~(extIrqPin ^ extCfg.activeHigh);

  // Wake requests only while powered down
  always_comb
  begin
    st_nxt                 = st_r;
    st_nxt.rstPrev         = rstPin;
    st_nxt.wake.extWake    = pdActive & (|pinActive);
    st_nxt.wake.keypadWake = pdActive & keypadMatch & keypadIrqEnable;
    st_nxt.wake.rstRise    = pdActive & rstPin & ~st_r.rstPrev;
  end

  // State register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign wake = st_r.wake;

endmodule : pmc_wake_detect

// ---- src/pmc_power_mode_controller.sv ----
/*
  Power-mode controller: idle and power-down entry, timed wakeup, reset
  cause and system event flags, detector one settings.
  Assumes an 8-bit register port driven by the CPU, synchronous pins, and
  a core that stops when its clock enable is low.
*/
`timescale 1ns/10ps
`include "pmc_consts.svh"

module pmc_power_mode_controller #(
  parameter int unsigned WAKE_COUNT = `PMC_WAKE_COUNT
) (
  input  wire logic            clock,
  input  wire logic            reset_n,
  input  wire logic [7:0]      sfrAddr,
  input  wire logic [7:0]      sfrWrData,
  input  wire logic            sfrWrEn,
  input  wire logic            sfrRdEn,
  output logic [7:0]           sfrRdData,
  input  pmc_pkg::pmc_events_s events,
  input  wire logic            missingClockIrqEnable,
  input  wire logic [7:0]      stackPointer,
  input  wire logic [7:0]      stackBoundary,
  input  wire logic            irqPending,
  input  wire logic            resetRequest,
  input  wire logic [3:0]      extIrqPin,
  input  pmc_pkg::pmc_extcfg_s extCfg,
  input  wire logic            keypadMatch,
  input  wire logic            keypadIrqEnable,
  input  wire logic            rstPin,
  input  wire logic            rtcWakeEnable,
  input  wire logic            wdtNonStop,
  input  wire logic            pcaIdleRun,
  input  wire logic            wdtIdleRun,
  output logic                 cpuClockEnable,
  output logic                 oscEnable,
  output logic                 flashPowered,
  output logic                 periphClockEnable,
  output logic                 pcaClockEnable,
  output logic                 wdtClockEnable,
  output logic                 ramWriteBlock,
  output logic                 coreResetHold,
  output logic                 keypadIrqTake,
  output logic                 systemResetReq,
  output logic                 detector1Run,
  output pmc_pkg::pmc_level_e  detector1Level
);
  import pmc_pkg::*;

  typedef struct packed
  {
    pmc_state_e state;
    logic [7:0] pctl0;
    logic [7:0] flags;
    logic [7:0] pctl2;
    logic [7:0] rdData;
    logic       cpuClkEn;
    logic       oscEn;
    logic       flashOn;
    logic       periphEn;
    logic       pcaEn;
    logic       wdtEn;
    logic       ramWrBlock;
    logic       coreRst;
    logic       keypadIrq;
    logic       sysRstReq;
    logic       det1Run;
    logic [1:0] holdCnt;
    logic       wakeByRst;
    logic       wakeByKeypad;
  } pmc_top_s;

  pmc_top_s  st_r;
  pmc_top_s  st_nxt;
  pmc_wake_s wake;
  logic      timerDone;
  logic      wakeAny;
  logic      wrPctl0;
  logic      wrFlags;
  logic      wrPctl2;
  logic      stackHigh;
  logic [7:0] flagSet;
  logic [7:0] flagClr;

  // Write-one-to-clear with set winning over clear
  function automatic logic [7:0] pmc_w1c(input logic [7:0] cur, input logic [7:0] set,
                                         input logic [7:0] clr);
    pmc_w1c = (cur & ~clr) | set;
  endfunction : pmc_w1c

  // Address hit for a write strobe
  function automatic logic pmc_hit(input logic [7:0] addr, input logic [7:0] reg_addr,
                                   input logic strobe);
    pmc_hit = strobe && (addr == reg_addr);
  endfunction : pmc_hit

  // Wake detection and oscillator restart timer
  pmc_wake_detect u_detect (
    .clock           (clock),
    .reset_n         (reset_n),
    .pdActive        (st_r.state == PMC_PDOWN),
    .extIrqPin       (extIrqPin),
    .extCfg          (extCfg),
    .keypadMatch     (keypadMatch),
    .keypadIrqEnable (keypadIrqEnable),
    .rstPin          (rstPin),
    .wake            (wake)
  );

  pmc_wake_timer #(
    .WAKE_COUNT (WAKE_COUNT)
  ) u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (st_r.state == PMC_WAKE_TIMING),
    .done    (timerDone)
  );

  // Register strobes and power-down wake sources
  assign wrPctl0   = pmc_hit(sfrAddr, `PMC_ADDR_PCTL0, sfrWrEn);
  assign wrFlags   = pmc_hit(sfrAddr, `PMC_ADDR_FLAGS, sfrWrEn);
  assign wrPctl2   = pmc_hit(sfrAddr, `PMC_ADDR_PCTL2, sfrWrEn);
  assign stackHigh = stackPointer >= stackBoundary;
  assign wakeAny = wake.rstRise | wake.extWake | wake.keypadWake
                 | (rtcWakeEnable & events.rtcOverflow)
                 | (st_r.det1Run & events.bod1Match)
                 | (wdtNonStop & events.wdtOverflow);

  // Event flag set and clear masks
  always_comb
  begin
    flagSet = 8'h00;
    flagClr = wrFlags ? sfrWrData : 8'h00;
    flagSet[`PMC_B_SOFTRST] = events.softReset;
    flagSet[`PMC_B_PINRST]  = events.pinReset;
    flagSet[`PMC_B_MISSCLK] = events.missingClock & missingClockIrqEnable;
    flagSet[`PMC_B_RTCOVF]  = events.rtcOverflow;
    flagSet[`PMC_B_BROWNOUT_DETECTOR_ONE]    = events.bod1Match & st_r.det1Run;
    flagSet[`PMC_B_BROWNOUT_DETECTOR_ZERO]    = events.bod0Match;
    flagSet[`PMC_B_WDTOVF]  = events.wdtOverflow;
    flagSet[`PMC_B_STACKW]  = stackHigh;
    flagClr[`PMC_B_STACKW]  = flagClr[`PMC_B_STACKW] & ~stackHigh;
  end

  // Registers, mode sequencing and outputs
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.keypadIrq = 1'b0;
    st_nxt.flags     = pmc_w1c(st_r.flags, flagSet, flagClr);
    st_nxt.pctl0[`PMC_B_POWERON] = events.powerOn
      | (st_r.pctl0[`PMC_B_POWERON] & ~(wrPctl0 & sfrWrData[`PMC_B_POWERON]));
    if (wrPctl0)
    begin
      st_nxt.pctl0 = (sfrWrData & `PMC_PCTL0_GENMASK)
                   | (st_nxt.pctl0 & ~`PMC_PCTL0_GENMASK);
      st_nxt.pctl0[`PMC_B_IDLE]  = sfrWrData[`PMC_B_IDLE];
      st_nxt.pctl0[`PMC_B_PDOWN] = sfrWrData[`PMC_B_PDOWN];
    end
    if (wrPctl2)
      st_nxt.pctl2 = (sfrWrData & `PMC_PCTL2_WMASK) | `PMC_PCTL2_FIXED;
    case (st_r.state)
      PMC_RUN:
      begin
        if (st_nxt.pctl0[`PMC_B_PDOWN])
          st_nxt.state = PMC_PDOWN;
        else if (st_nxt.pctl0[`PMC_B_IDLE])
          st_nxt.state = PMC_IDLE;
      end
      PMC_IDLE:
      begin
        if (resetRequest)
        begin
          st_nxt.state   = PMC_IDLE_RST_HOLD;
          st_nxt.holdCnt = `PMC_IDLE_RST_MC;
          st_nxt.pctl0[`PMC_B_IDLE] = 1'b0;
        end
        else if (irqPending)
        begin
          st_nxt.state = PMC_RUN;
          st_nxt.pctl0[`PMC_B_IDLE] = 1'b0;
        end
      end
      PMC_PDOWN:
      begin
        if (wakeAny)
        begin
          st_nxt.state        = PMC_WAKE_TIMING;
          st_nxt.wakeByRst    = wake.rstRise;
          st_nxt.wakeByKeypad = wake.keypadWake;
          st_nxt.pctl0[`PMC_B_PDOWN] = 1'b0;
        end
      end
      PMC_WAKE_TIMING:
      begin
        if (timerDone)
        begin
          if (st_r.wakeByRst)
            st_nxt.state = PMC_WAIT_RST_LOW;
          else
          begin
            st_nxt.state     = PMC_RUN;
            st_nxt.keypadIrq = st_r.wakeByKeypad;
          end
        end
      end
      PMC_WAIT_RST_LOW:
      begin
        if (!rstPin)
          st_nxt.state = PMC_RUN;
      end
      PMC_IDLE_RST_HOLD:
      begin
        if (st_r.holdCnt == `PMC_HOLD_ONE)
          st_nxt.state = PMC_CORE_RESET;
        st_nxt.holdCnt = st_r.holdCnt - `PMC_HOLD_ONE;
      end
      PMC_CORE_RESET:
      begin
        if (!resetRequest)
          st_nxt.state = PMC_RUN;
      end
      default:
        st_nxt.state = PMC_RUN;
    endcase
    st_nxt.cpuClkEn   = (st_nxt.state != PMC_IDLE) && (st_nxt.state != PMC_PDOWN)
                     && (st_nxt.state != PMC_WAKE_TIMING);
    st_nxt.oscEn      = st_nxt.state != PMC_PDOWN;
    st_nxt.flashOn    = st_nxt.state != PMC_PDOWN;
    st_nxt.periphEn   = st_nxt.oscEn;
    st_nxt.pcaEn      = st_nxt.oscEn && ((st_nxt.state != PMC_IDLE) || pcaIdleRun);
    st_nxt.wdtEn      = (st_nxt.state == PMC_PDOWN) ? wdtNonStop
                      : ((st_nxt.state != PMC_IDLE) || wdtIdleRun);
    st_nxt.ramWrBlock = st_nxt.state == PMC_IDLE_RST_HOLD;
    st_nxt.coreRst    = (st_nxt.state == PMC_CORE_RESET)
                     || (st_nxt.state == PMC_WAIT_RST_LOW);
    st_nxt.sysRstReq  = (st_nxt.flags[`PMC_B_BROWNOUT_DETECTOR_ONE] & st_nxt.pctl2[`PMC_B_BOD1RE])
                      | (st_nxt.flags[`PMC_B_BROWNOUT_DETECTOR_ZERO] & st_nxt.pctl2[`PMC_B_BOD0RE]);
    st_nxt.det1Run    = st_nxt.pctl2[`PMC_B_BOD1EN]
                     && ((st_nxt.state != PMC_PDOWN) || st_nxt.pctl2[`PMC_B_KEEPAWAKE]);
    // Read data, zero for unmapped addresses
    if (sfrRdEn)
    begin
      case (sfrAddr)
        `PMC_ADDR_PCTL0: st_nxt.rdData = st_r.pctl0;
        `PMC_ADDR_FLAGS: st_nxt.rdData = st_r.flags;
        `PMC_ADDR_PCTL2: st_nxt.rdData = st_r.pctl2;
        default:         st_nxt.rdData = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r          <= '0;
      st_r.state    <= PMC_RUN;
      st_r.pctl0    <= `PMC_RST_PCTL0;
      st_r.flags    <= `PMC_RST_FLAGS;
      st_r.pctl2    <= `PMC_RST_PCTL2;
      st_r.cpuClkEn <= 1'b1;
      st_r.oscEn    <= 1'b1;
      st_r.flashOn  <= 1'b1;
      st_r.periphEn <= 1'b1;
      st_r.pcaEn    <= 1'b1;
      st_r.wdtEn    <= 1'b1;
      st_r.det1Run  <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from the state register
  assign sfrRdData         = st_r.rdData;
  assign cpuClockEnable    = st_r.cpuClkEn;
  assign oscEnable         = st_r.oscEn;
  assign flashPowered      = st_r.flashOn;
  assign periphClockEnable = st_r.periphEn;
  assign pcaClockEnable    = st_r.pcaEn;
  assign wdtClockEnable    = st_r.wdtEn;
  assign ramWriteBlock     = st_r.ramWrBlock;
  assign coreResetHold     = st_r.coreRst;
  assign keypadIrqTake     = st_r.keypadIrq;
  assign systemResetReq    = st_r.sysRstReq;
  assign detector1Run      = st_r.det1Run;
  assign detector1Level    = pmc_level_e'(st_r.pctl2[`PMC_B_LVL_HI:`PMC_B_LVL_LO]);

  // Checks on mode sequencing and flags
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_idle_clock;
    st_r.state == PMC_IDLE |-> !st_r.cpuClkEn && st_r.oscEn;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("CPU clock on in idle");
  property p_idle_periph;
    st_r.state == PMC_IDLE |-> st_r.periphEn && (st_r.pcaEn == pcaIdleRun);
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("Idle peripheral clocks");
  property p_idle_exit;
    st_r.state == PMC_IDLE && irqPending && !resetRequest |=> st_r.state == PMC_RUN
      && st_r.cpuClkEn;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("Idle not left on interrupt");
  property p_pd_off;
    st_r.state == PMC_PDOWN |-> !st_r.oscEn && !st_r.flashOn && !st_r.cpuClkEn;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Oscillator on in power-down");
  property p_pd_stay;
    st_r.state == PMC_PDOWN && !wakeAny |=> st_r.state == PMC_PDOWN;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("Power-down left without wake");
  property p_wake_gate;
    $rose(st_r.state == PMC_WAKE_TIMING) |-> !st_r.cpuClkEn [*4];
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("Clock released early");
  property p_rst_low;
    st_r.state == PMC_WAIT_RST_LOW && rstPin |=> st_r.state == PMC_WAIT_RST_LOW
      && st_r.coreRst;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("Ran with reset pin high");
  property p_ram_block;
    $rose(st_r.state == PMC_IDLE_RST_HOLD) |-> st_r.ramWrBlock [*2] ##1 st_r.coreRst;
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("RAM write block length");
  property p_mode_clear;
    $fell(st_r.state == PMC_IDLE) |-> !st_r.pctl0[`PMC_B_IDLE];
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("Idle bit kept on exit");
  property p_poweron;
    events.powerOn |=> st_r.pctl0[`PMC_B_POWERON];
  endproperty
  a_poweron: assert property (p_poweron) else $error("Power-on flag not set");
  property p_stack;
    stackHigh |=> st_r.flags[`PMC_B_STACKW];
  endproperty
  a_stack: assert property (p_stack) else $error("Stack warning lost");
  property p_bod_reset;
    st_r.flags[`PMC_B_BROWNOUT_DETECTOR_ONE] && st_r.pctl2[`PMC_B_BOD1RE] |-> st_r.sysRstReq;
  endproperty
  a_bod_reset: assert property (p_bod_reset) else $error("Detector reset missing");

  c_idle_irq: cover property (st_r.state == PMC_IDLE ##1 st_r.state == PMC_RUN);
  c_pd_int: cover property (st_r.state == PMC_WAKE_TIMING ##1 st_r.state == PMC_RUN);
  c_pd_rst: cover property (st_r.state == PMC_WAIT_RST_LOW ##1 st_r.state == PMC_RUN);
  c_keypad: cover property (st_r.keypadIrq);

endmodule : pmc_power_mode_controller

// ---- bench/pmc_pin_model.sv ----
/*
  Far-side model: external interrupt pins, keypad match and reset pin.
  Assumes the bench changes wakeKind only at a rising clock edge.
*/
`timescale 1ns/10ps

module pmc_pin_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [1:0] wakeKind,
  input  wire logic       cpuClockEnable,
  input  wire logic       coreResetHold,
  output logic [3:0]      extIrqPin,
  output logic            keypadMatch,
  output logic            rstPin
);
  logic servedR;

  // Remembers that the device came back; released pins idle at pull level
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      servedR <= 1'h0;
    else
      servedR <= (wakeKind != 2'h0) &&
                 (servedR || (wakeKind == 2'h3 ? coreResetHold : cpuClockEnable));
  end

  assign extIrqPin   = {3'h7, !(wakeKind == 2'h1 && !servedR)};
  assign keypadMatch = (wakeKind == 2'h2) && !servedR;
  assign rstPin      = (wakeKind == 2'h3) && !servedR;
endmodule : pmc_pin_model

// ---- bench/tb_top.sv ----
/*
  Self-checking bench of the power-mode controller with a pin model.
  Assumes the design package and header are compiled first.
*/
`timescale 1ns/10ps

module tb_top;
  import pmc_pkg::*;
  localparam int WK = 4;
  logic       clock = 1'h0, reset_n = 1'h0, sfrWrEn = 1'h0, sfrRdEn = 1'h0;
  logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
  logic [7:0] stackPointer = 8'h00, stackBoundary = 8'hf0;
  logic       missingClockIrqEnable = 1'h0, irqPending = 1'h0, resetRequest = 1'h0;
  logic       keypadIrqEnable = 1'h1, rtcWakeEnable = 1'h0, wdtNonStop = 1'h0;
  logic       pcaIdleRun = 1'h1, wdtIdleRun = 1'h0;
  pmc_events_s events = '0;
  pmc_extcfg_s extCfg = '{enable: 4'h1, activeHigh: 4'h0};
  logic [1:0] wakeKind = 2'h0;
  logic [3:0] extIrqPin;
  logic       keypadMatch, rstPin, cpuClockEnable, oscEnable, flashPowered, periphClockEnable;
  logic       pcaClockEnable, wdtClockEnable, ramWriteBlock, coreResetHold, keypadIrqTake;
  logic       systemResetReq, detector1Run;
  pmc_level_e detector1Level;
  int         err_count = 0, n_tests = 0, takes = 0;

  pmc_power_mode_controller #(.WAKE_COUNT(WK)) i_pmc_power_mode_controller (
    .clock, .reset_n, .sfrAddr, .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData, .events,
    .missingClockIrqEnable, .stackPointer, .stackBoundary, .irqPending, .resetRequest,
    .extIrqPin, .extCfg, .keypadMatch, .keypadIrqEnable, .rstPin, .rtcWakeEnable,
    .wdtNonStop, .pcaIdleRun, .wdtIdleRun, .cpuClockEnable, .oscEnable, .flashPowered,
    .periphClockEnable, .pcaClockEnable, .wdtClockEnable, .ramWriteBlock, .coreResetHold,
    .keypadIrqTake, .systemResetReq, .detector1Run, .detector1Level);

  pmc_pin_model i_pmc_pin_model (.clock, .reset_n, .wakeKind, .cpuClockEnable,
    .coreResetHold, .extIrqPin, .keypadMatch, .rstPin);

  // Clock and keypad interrupt pulse counter
  always #10 clock = ~clock;
  always @(negedge clock) if (keypadIrqTake === 1'h1) takes++;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'h1;
    @(posedge clock);
    sfrWrEn <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    sfrAddr <= a;
    sfrRdEn <= 1'h1;
    @(posedge clock);
    sfrRdEn <= 1'h0;
    @(negedge clock);
    v = sfrRdData;
  endtask : rd

  task automatic pulse(input pmc_events_s e);
    @(posedge clock);
    events <= e;
    @(posedge clock);
    events <= '0;
  endtask : pulse

  task automatic t_regs;
    logic [7:0] v;
    rd(8'h44, v); chk(v, 8'h05);
    rd(8'h97, v); chk(v, 8'h00);
    rd(8'h10, v); chk(v, 8'h00);
    for (int lv = 0; lv < 4; lv++)
    begin
      wr(8'h44, {2'h0, 2'(lv), 4'h4});
      rd(8'h44, v); chk(v, {2'h0, 2'(lv), 4'h5});
      chk(8'(detector1Level), 8'(lv));
    end
    wr(8'h44, 8'hff);
    rd(8'h44, v); chk(v, 8'hbf);
    pulse(8'h04);
    @(negedge clock); chk(8'(systemResetReq), 8'h01);
    wr(8'h97, 8'hff);
    wr(8'h44, 8'h05);
    @(negedge clock); chk(8'(systemResetReq), 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_flags;
    logic [7:0] v;
    stackPointer <= stackBoundary;
    pulse(8'hff);
    rd(8'h97, v); chk(v, 8'hdf);
    rd(8'h87, v); chk(v, 8'h10);
    missingClockIrqEnable <= 1'h1;
    pulse(8'h10);
    rd(8'h97, v); chk(v, 8'hff);
    wr(8'h97, 8'hff);
    rd(8'h97, v); chk(v, 8'h08);
    stackPointer <= 8'hef;
    wr(8'h97, 8'h08);
    rd(8'h97, v); chk(v, 8'h00);
    wr(8'h87, 8'h10);
    rd(8'h87, v); chk(v, 8'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_idle;
    logic [7:0] v;
    wr(8'h87, 8'h01);
    @(negedge clock); chk(8'(cpuClockEnable), 8'h00);
    chk({5'h0, periphClockEnable, pcaClockEnable, wdtClockEnable}, 8'h06);
    @(posedge clock) irqPending <= 1'h1;
    @(posedge clock) irqPending <= 1'h0;
    @(negedge clock); chk(8'(cpuClockEnable), 8'h01);
    rd(8'h87, v); chk(v, 8'h00);
    $display("test idle done");
  endtask : t_idle

  task automatic t_idle_rst;
    int n;
    n = 0;
    wr(8'h87, 8'h01);
    @(posedge clock) resetRequest <= 1'h1;
    repeat (6) @(negedge clock) n += int'(ramWriteBlock);
    chk(8'(n), 8'h02);
    chk(8'(coreResetHold), 8'h01);
    @(posedge clock) resetRequest <= 1'h0;
    repeat (3) @(negedge clock);
    chk({6'h0, coreResetHold, cpuClockEnable}, 8'h01);
    $display("test idle reset done");
  endtask : t_idle_rst

  task automatic t_wake(input logic [1:0] kind);
    int n;
    int t0;
    logic [7:0] v;
    n = 0;
    t0 = takes;
    repeat (200) @(posedge clock);
    wr(8'h87, 8'h02);
    @(negedge clock); chk({6'h0, oscEnable, flashPowered}, 8'h00);
    chk(8'(detector1Run), 8'h00);
    repeat (8) @(posedge clock);
    chk(8'(oscEnable), 8'h00);
    wakeKind <= kind;
    while (cpuClockEnable !== 1'h1 && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    chk(8'(n > WK), 8'h01);
    chk(8'(n < WK + 8), 8'h01);
    if (kind == 2'h3)
    begin
      chk(8'(coreResetHold), 8'h01);
      n = 0;
      while (coreResetHold !== 1'h0 && n < 50)
      begin
        @(negedge clock);
        n++;
      end
      chk(8'(n < 50), 8'h01);
    end
    repeat (2) @(negedge clock);
    chk(8'(takes - t0), (kind == 2'h2) ? 8'h01 : 8'h00);
    @(posedge clock) wakeKind <= 2'h0;
    rd(8'h87, v); chk(v, 8'h00);
    $display("test wake %0d done", kind);
  endtask : t_wake

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    t_regs;
    t_flags;
    t_idle;
    t_idle_rst;
    t_wake(2'h1);
    t_wake(2'h2);
    t_wake(2'h3);
    wrap_up;
  end

  // Watchdog, far beyond the expected few hundred cycles
  initial
  begin
    #400000;
    err_count++;
    wrap_up;
  end
endmodule : tb_top
